// [verilog/gpf_pkg.sv]
// Register map, field layout and reset values of the port controller
package gpf_pkg;
  localparam int unsigned NPIN = 16;
  localparam logic [11:0] OFS_DIR = 12'h000;
  localparam logic [11:0] OFS_ODMODE = 12'h004;
  localparam logic [11:0] OFS_PDN = 12'h00C;
  localparam logic [11:0] OFS_PUP = 12'h010;
  localparam logic [11:0] OFS_AFH = 12'h014;
  localparam logic [11:0] OFS_AFL = 12'h018;
  localparam logic [11:0] OFS_ANA = 12'h01C;
  localparam logic [11:0] OFS_RISE = 12'h024;
  localparam logic [11:0] OFS_FALL = 12'h028;
  localparam logic [11:0] OFS_FLAGS = 12'h034;
  localparam logic [11:0] OFS_FCLR = 12'h038;
  localparam logic [11:0] OFS_FILT = 12'h040;
  localparam logic [11:0] OFS_IN = 12'h050;
  localparam logic [11:0] OFS_ODR = 12'h054;
  localparam logic [11:0] OFS_BCLR = 12'h058;
  localparam logic [11:0] OFS_BSC = 12'h05C;
  localparam logic [11:0] OFS_TOG = 12'h060;
  // Filter clock select field inside the filter configuration word
  localparam int unsigned FCS_LSB = 16;
  localparam int unsigned FCS_MSB = 18;
  // Set half and clear half of the set/clear word
  localparam int unsigned BSC_CLR_LSB = 16;
  // Reset values: debug pins 13/14 digital with pull-up, the rest analog
  localparam logic [15:0] RST_DIR = 16'hFFFF;
  localparam logic [15:0] RST_ANA = 16'h9FFF;
  localparam logic [15:0] RST_PUP = 16'h6000;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [2:0] DIV8_ALL = 3'h7;
  localparam logic [1:0] DIV4_ALL = 2'h3;

  typedef enum logic [2:0] {
    FCS_DIV2, FCS_DIV4, FCS_DIV8, FCS_BTIM,
    FCS_RCMID, FCS_LSI, FCS_RCSLOW, FCS_AWT
  } gpf_fcs_e;

  // Pad control bundle toward the I/O cells
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
    logic [15:0] analog;
  } gpf_pad_s;

  // Filter clock source ticks, one-cycle pulses in the pclk domain
  typedef struct packed {
    logic basic_timer_one;
    logic mid_rate_rc_oscillator;
    logic low_speed_internal_osc;
    logic slow_rate_rc_oscillator;
    logic auto_wakeup_timer;
  } gpf_tick_s;
endpackage : gpf_pkg

// [verilog/gpf_port.sv]
// Sixteen-pin I/O port with edge flags, input filter and APB registers
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Digital input pins flag rising, falling or both edges in one shared bit.
// - An enabled edge sets that pin's flag, readable by software.
// - Writing the clear register clears only the addressed pins' flags.
// - Filter select codes 0-2 give bus clock /2,/4,/8; code 3 timer one overflow.
// - Codes 4-7 select mid RC, low-speed oscillator, slow RC, wakeup timer overflow.
// - With filtering, changes shorter than one filter period never reach edge logic.
// - With filtering, changes lasting over two filter periods always pass.
// - Edge flags work in low-power states and then request wake-up.
// - One filter clock selection serves every pin of the port.
// - Set/clear and bit-clear writes of 1 change only matching latch bits.
// - Writing 1 to the toggle register inverts that pin's output level.
// - Reset leaves debug pins digital with pull-up, others analog without pulls.
// - Direction bit 0 makes the pin an output, 1 an input.
// - Output mode bit 0 gives push-pull, 1 open-drain drive.
// - Analog select 1 gives analog function, 0 digital.
// - A filter configuration bit of 1 enables filtering for that pin.
// - Rise and fall enable registers pick the flagging edge types per pin.
// - Pull-up and pull-down both enabled applies the pull-up only.
module gpf_port
  import gpf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and pad control
  input wire logic [15:0] pin_in,
  output gpf_pad_s pad_ctrl,
  output logic [63:0] alt_func_sel,
  // Filter clock sources
  input wire gpf_tick_s filt_ticks,
  // Power and interrupt
  input wire logic low_power_mode,
  output logic port_irq,
  output logic wakeup_req
);
  logic [15:0] dir_q, odmode_q, pdn_q, pup_q, ana_q, rise_q, fall_q;
  logic [15:0] filt_en_q, odr_q, flags_q, sync1_q, sync2_q, smp_q, filt_q, prev_q;
  logic [31:0] afh_q, afl_q, prdata_q;
  logic [2:0] fcs_q, div_q;
  logic pslverr_q;
  gpf_pad_s pad_q;
  logic wr, setup, known;
  logic [31:0] rdata;
  logic tick;
  logic [15:0] edge_in, rise_ev, fall_ev, digin, flag_clr;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= RST_DIR;
      ana_q <= RST_ANA;
      pup_q <= RST_PUP;
      odmode_q <= RST_ZERO;
      pdn_q <= RST_ZERO;
      rise_q <= RST_ZERO;
      fall_q <= RST_ZERO;
      filt_en_q <= RST_ZERO;
      fcs_q <= FCS_DIV2;
      afh_q <= '0;
      afl_q <= '0;
    end else if (wr) begin
      if (paddr == OFS_DIR) begin
        dir_q <= pwdata[15:0];
      end else if (paddr == OFS_ODMODE) begin
        odmode_q <= pwdata[15:0];
      end else if (paddr == OFS_PDN) begin
        pdn_q <= pwdata[15:0];
      end else if (paddr == OFS_PUP) begin
        pup_q <= pwdata[15:0];
      end else if (paddr == OFS_AFH) begin
        afh_q <= pwdata;
      end else if (paddr == OFS_AFL) begin
        afl_q <= pwdata;
      end else if (paddr == OFS_ANA) begin
        ana_q <= pwdata[15:0];
      end else if (paddr == OFS_RISE) begin
        rise_q <= pwdata[15:0];
      end else if (paddr == OFS_FALL) begin
        fall_q <= pwdata[15:0];
      end else if (paddr == OFS_FILT) begin
        filt_en_q <= pwdata[15:0];
        fcs_q <= pwdata[FCS_MSB:FCS_LSB];
      end
    end
  end

  // Output latch with atomic set, clear and toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odr_q <= RST_ZERO;
    end else if (wr) begin
      if (paddr == OFS_ODR) begin
        odr_q <= pwdata[15:0];
      end else if (paddr == OFS_BCLR) begin
        odr_q <= odr_q & ~pwdata[15:0];
      end else if (paddr == OFS_BSC) begin
        // Set half wins over clear half on the same pin
        odr_q <= (odr_q & ~pwdata[31:BSC_CLR_LSB]) | pwdata[15:0];
      end else if (paddr == OFS_TOG) begin
        odr_q <= odr_q ^ pwdata[15:0];
      end
    end
  end

  // Pad drive, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
    end else begin
      pad_q.analog <= ana_q;
      pad_q.out <= odr_q & ~odmode_q;
      pad_q.oe <= ~dir_q & ~ana_q & (~odmode_q | ~odr_q);
      pad_q.pull_up <= pup_q & ~ana_q;
      pad_q.pull_down <= pdn_q & ~pup_q & ~ana_q;
    end
  end
  assign pad_ctrl = pad_q;
  assign alt_func_sel = {afh_q, afl_q};

  // Input synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= RST_ZERO;
      sync2_q <= RST_ZERO;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Filter tick selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    case (gpf_fcs_e'(fcs_q))
      FCS_DIV2: tick = div_q[0];
      FCS_DIV4: tick = (div_q[1:0] == DIV4_ALL);
      FCS_DIV8: tick = (div_q == DIV8_ALL);
      FCS_BTIM: tick = filt_ticks.basic_timer_one;
      FCS_RCMID: tick = filt_ticks.mid_rate_rc_oscillator;
      FCS_LSI: tick = filt_ticks.low_speed_internal_osc;
      FCS_RCSLOW: tick = filt_ticks.slow_rate_rc_oscillator;
      default: tick = filt_ticks.auto_wakeup_timer;
    endcase
  end

  // Two-sample glitch filter; tracks the input while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q <= RST_ZERO;
      filt_q <= RST_ZERO;
    end else begin
      if (tick) begin
        smp_q <= sync2_q;
      end
      filt_q <= (~filt_en_q & sync2_q)
              | (filt_en_q & (tick ? ((sync2_q & ~(sync2_q ^ smp_q))
                                      | (filt_q & (sync2_q ^ smp_q)))
                                   : filt_q));
    end
  end

  // Edge detection and sticky flags
  assign edge_in = (filt_en_q & filt_q) | (~filt_en_q & sync2_q);
  assign digin = dir_q & ~ana_q;
  assign rise_ev = digin & rise_q & edge_in & ~prev_q;
  assign fall_ev = digin & fall_q & ~edge_in & prev_q;
  assign flag_clr = (wr && paddr == OFS_FCLR) ? ~pwdata[15:0] : RST_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= RST_ZERO;
      flags_q <= RST_ZERO;
    end else begin
      prev_q <= edge_in;
      // New event wins over a clear in the same cycle
      flags_q <= (flags_q & ~flag_clr) | rise_ev | fall_ev;
    end
  end

  assign port_irq = |flags_q;
  assign wakeup_req = port_irq & low_power_mode;

  // Read mux, captured in the setup cycle
  always_comb begin
    rdata = '0;
    known = 1'b1;
    if (paddr == OFS_DIR) begin
      rdata[15:0] = dir_q;
    end else if (paddr == OFS_ODMODE) begin
      rdata[15:0] = odmode_q;
    end else if (paddr == OFS_PDN) begin
      rdata[15:0] = pdn_q;
    end else if (paddr == OFS_PUP) begin
      rdata[15:0] = pup_q;
    end else if (paddr == OFS_AFH) begin
      rdata = afh_q;
    end else if (paddr == OFS_AFL) begin
      rdata = afl_q;
    end else if (paddr == OFS_ANA) begin
      rdata[15:0] = ana_q;
    end else if (paddr == OFS_RISE) begin
      rdata[15:0] = rise_q;
    end else if (paddr == OFS_FALL) begin
      rdata[15:0] = fall_q;
    end else if (paddr == OFS_FLAGS) begin
      rdata[15:0] = flags_q;
    end else if (paddr == OFS_FILT) begin
      rdata[15:0] = filt_en_q;
      rdata[FCS_MSB:FCS_LSB] = fcs_q;
    end else if (paddr == OFS_IN) begin
      rdata[15:0] = sync2_q;
    end else if (paddr == OFS_ODR) begin
      rdata[15:0] = odr_q;
    end else if (paddr == OFS_FCLR || paddr == OFS_BCLR) begin
      rdata = '0;
    end else if (paddr == OFS_BSC || paddr == OFS_TOG) begin
      rdata = '0;
    end else begin
      known = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata;
      pslverr_q <= ~known;
    end
  end

  // Checks
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (rise_ev | fall_ev) != 0 |=> (flags_q & $past(rise_ev | fall_ev)) == $past(rise_ev | fall_ev))
    else $error("edge event did not set its flag");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_FCLR && !pwdata[0] && !rise_ev[0] && !fall_ev[0] |=> !flags_q[0])
    else $error("clear write left flag 0 set");
  a_clear_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_FCLR && pwdata[1] && flags_q[1] |=> flags_q[1])
    else $error("writing 1 to clear dropped flag 1");
  a_irq_or: assert property (@(posedge pclk) disable iff (!presetn)
    port_irq == (flags_q != 0))
    else $error("port request not the OR of flags");
  a_glitch_block: assert property (@(posedge pclk) disable iff (!presetn)
    filt_en_q[3] && tick && sync2_q[3] != smp_q[3] |=> filt_q[3] == $past(filt_q[3]))
    else $error("filter passed an unconfirmed sample");
  a_filter_pass: assert property (@(posedge pclk) disable iff (!presetn)
    filt_en_q[3] && tick && sync2_q[3] == smp_q[3] |=> filt_q[3] == $past(sync2_q[3]))
    else $error("filter missed two equal samples");
  a_toggle_odr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_TOG |=> odr_q == ($past(odr_q) ^ $past(pwdata[15:0])))
    else $error("toggle write gave wrong latch");
  a_bclr_only: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_BCLR |=> odr_q == ($past(odr_q) & ~$past(pwdata[15:0])))
    else $error("bit clear touched other bits");
  a_pull_prio: assert property (@(posedge pclk) disable iff (!presetn)
    pup_q[3] && pdn_q[3] && !ana_q[3] |=> pad_q.pull_up[3] && !pad_q.pull_down[3])
    else $error("pull-down applied with pull-up");
  a_wake_req: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_mode && (rise_ev | fall_ev) != 0 |=> wakeup_req || !low_power_mode)
    else $error("no wake-up after edge in low power");
  a_oe_dir: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q[2] |=> !pad_q.oe[2])
    else $error("input pin is driven");
  // Latch, pad, flag, filter, wake-up and tick checks
  a_bsc_latch: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_BSC |=> odr_q == (($past(odr_q) & ~$past(pwdata[31:16])) | $past(pwdata[15:0])))
    else $error("set/clear write gave wrong latch");
  a_od_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_q[5] && !ana_q[5] && odmode_q[5] |=> !pad_q.out[5] && pad_q.oe[5] == !$past(odr_q[5]))
    else $error("open-drain pin drove high");
  a_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_q[5] && !ana_q[5] && !odmode_q[5] |=> pad_q.oe[5] && pad_q.out[5] == $past(odr_q[5]))
    else $error("push-pull pin not driving its latch");
  a_ana_pad: assert property (@(posedge pclk) disable iff (!presetn)
    ana_q[6] |=> pad_q.analog[6] && !pad_q.oe[6] && !pad_q.pull_up[6] && !pad_q.pull_down[6])
    else $error("analog pin kept digital drive or pulls");
  a_ana_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ana_q[4] |-> !rise_ev[4] && !fall_ev[4])
    else $error("analog pin raised an edge event");
  a_out_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_q[0] |-> !rise_ev[0] && !fall_ev[0])
    else $error("output pin raised an edge event");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[0] && !(wr && paddr == OFS_FCLR && !pwdata[0]) |=> flags_q[0])
    else $error("flag 0 dropped without a clear");
  a_flag_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_q[1] && !rise_ev[1] && !fall_ev[1] |=> !flags_q[1])
    else $error("flag 1 set without an enabled edge");
  a_unfilt_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !filt_en_q[7] |-> edge_in[7] == sync2_q[7])
    else $error("unfiltered pin not seen directly");
  a_filt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    filt_en_q[3] && !tick |=> filt_q[3] == $past(filt_q[3]))
    else $error("filter output moved between ticks");
  a_wake_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !low_power_mode |-> !wakeup_req)
    else $error("wake-up requested while active");
  a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    fcs_q == FCS_DIV4 && tick && !(wr && paddr == OFS_FILT) |=> !tick)
    else $error("divided filter tick lasted two cycles");
  a_btim_sel: assert property (@(posedge pclk) disable iff (!presetn)
    fcs_q == FCS_BTIM |-> tick == filt_ticks.basic_timer_one)
    else $error("timer overflow not used as filter tick");
  a_awt_sel: assert property (@(posedge pclk) disable iff (!presetn)
    fcs_q == FCS_AWT |-> tick == filt_ticks.auto_wakeup_timer)
    else $error("wakeup timer overflow not used as filter tick");
  a_pdn_alone: assert property (@(posedge pclk) disable iff (!presetn)
    pdn_q[9] && !pup_q[9] && !ana_q[9] |=> pad_q.pull_down[9])
    else $error("lone pull-down not applied");
  c_rise: cover property (@(posedge pclk) disable iff (!presetn) rise_ev != 0);
  c_fall: cover property (@(posedge pclk) disable iff (!presetn) fall_ev != 0);
  c_filtered: cover property (@(posedge pclk) disable iff (!presetn)
    filt_en_q[3] && $rose(filt_q[3]));
  c_wake: cover property (@(posedge pclk) disable iff (!presetn) $rose(wakeup_req));
  c_cleared: cover property (@(posedge pclk) disable iff (!presetn) $fell(port_irq));
endmodule : gpf_port
`default_nettype wire

// [bench/gpf_pin_model.sv]
// Model of the pins and filter tick sources around the port
`timescale 1ns/1ns
`default_nettype none
module gpf_pin_model
  import gpf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pad side
  input wire gpf_pad_s pad_ctrl,
  input wire logic [15:0] ext_lvl,
  output logic [15:0] pin_in,
  // Tick sources
  output gpf_tick_s filt_ticks
);
  logic [2:0] cnt_q [5];
  // A driven pin shows the pad value, a released one the outside level
  assign pin_in = (pad_ctrl.oe & pad_ctrl.out) | (~pad_ctrl.oe & ext_lvl);
  // Source i ticks every 3+i cycles, so code c = 3+i ticks every c cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) begin
        cnt_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        cnt_q[i] <= (cnt_q[i] == 3'(2 + i)) ? 3'h0 : cnt_q[i] + 3'h1;
      end
    end
  end
  assign filt_ticks = {cnt_q[0] == 3'h0, cnt_q[1] == 3'h0, cnt_q[2] == 3'h0,
                       cnt_q[3] == 3'h0, cnt_q[4] == 3'h0};
endmodule : gpf_pin_model
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the port controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gpf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] pin_in;
  logic [15:0] ext_lvl = 16'h0;
  gpf_pad_s pad_ctrl;
  logic [63:0] alt_func_sel;
  gpf_tick_s filt_ticks;
  logic low_power_mode = 1'b0;
  logic port_irq;
  logic wakeup_req;
  int errors = 0;
  int n_compared = 0;
  int seed = 36;
  logic [31:0] rd;
  logic err;

  always #5 pclk = ~pclk;

  gpf_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pad_ctrl(pad_ctrl), .alt_func_sel(alt_func_sel),
    .filt_ticks(filt_ticks), .low_power_mode(low_power_mode), .port_irq(port_irq),
    .wakeup_req(wakeup_req));
  gpf_pin_model u_pins (.pclk(pclk), .presetn(presetn), .pad_ctrl(pad_ctrl),
    .ext_lvl(ext_lvl), .pin_in(pin_in), .filt_ticks(filt_ticks));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Filter clock period in pclk cycles for each select code
  function automatic int fper(input int c);
    return (c < 3) ? (2 << c) : c;
  endfunction : fper

  function automatic logic [15:0] lat_next(input int k, input logic [15:0] l,
                                           input logic [31:0] d);
    case (k)
      0: return d[15:0];
      1: return (l & ~d[31:16]) | d[15:0];
      2: return l & ~d[15:0];
      default: return l ^ d[15:0];
    endcase
  endfunction : lat_next

  initial begin
    logic [11:0] lat_ofs [4];
    logic [15:0] lat;
    logic [31:0] v;
    logic [31:0] w;
    lat_ofs = '{OFS_ODR, OFS_BSC, OFS_BCLR, OFS_TOG};
    lat = 16'h0;
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    rdchk("dir", OFS_DIR, 32'h0000FFFF);
    rdchk("ana", OFS_ANA, 32'h00009FFF);
    rdchk("pup", OFS_PUP, 32'h00006000);
    chk("pad_ana", {16'h0, pad_ctrl.analog}, 32'h9FFF);
    chk("pad_pull", {pad_ctrl.pull_up, pad_ctrl.pull_down}, 32'h60000000);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("pready", {31'h0, pready}, 32'h1);
    apb(1'b1, OFS_FLAGS, 32'h0000FFFF);
    rdchk("flags_ro", OFS_FLAGS, 32'h0);
    v = $random(seed);
    w = $random(seed);
    apb(1'b1, OFS_AFH, v);
    apb(1'b1, OFS_AFL, w);
    rdchk("afh", OFS_AFH, v);
    chk("afh_pin", alt_func_sel[63:32], v);
    chk("afl_pin", alt_func_sel[31:0], w);
    // Output path: digital, push-pull outputs, reserved bits kept zero
    apb(1'b1, OFS_ANA, 32'h0);
    apb(1'b1, OFS_DIR, 32'h0);
    apb(1'b1, OFS_ODMODE, 32'h0);
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      if (i % 4 != 1) v[31:16] = 16'h0;
      apb(1'b1, lat_ofs[i % 4], v);
      lat = lat_next(i % 4, lat, v);
      rdchk("latch", OFS_ODR, {16'h0, lat});
      cyc(2);
      chk("pad_out", {pad_ctrl.out, pad_ctrl.oe}, {lat, 16'hFFFF});
    end
    apb(1'b1, OFS_ODMODE, 32'h0000FFFF);
    cyc(2);
    chk("pad_od", {pad_ctrl.out, pad_ctrl.oe}, {16'h0, ~lat});
    apb(1'b1, OFS_PDN, 32'h0000FFFF);
    apb(1'b1, OFS_PUP, 32'h000000FF);
    cyc(2);
    chk("pulls", {pad_ctrl.pull_up, pad_ctrl.pull_down}, 32'h00FFFF00);
    // Inputs and edge flags
    apb(1'b1, OFS_DIR, 32'h0000FFFF);
    apb(1'b1, OFS_ANA, 32'h00000010);
    ext_lvl <= 16'($random(seed));
    cyc(4);
    rdchk("insample", OFS_IN, {16'h0, ext_lvl});
    ext_lvl <= 16'h0;
    apb(1'b1, OFS_RISE, 32'h00000015);
    apb(1'b1, OFS_FALL, 32'h00000006);
    apb(1'b1, OFS_FCLR, 32'h0);
    ext_lvl <= 16'h001F;
    cyc(6);
    rdchk("rise", OFS_FLAGS, 32'h5);
    chk("no_wake", {30'h0, port_irq, wakeup_req}, 32'h2);
    ext_lvl <= 16'h0;
    low_power_mode <= 1'b1;
    cyc(6);
    rdchk("fall", OFS_FLAGS, 32'h7);
    chk("wake", {30'h0, port_irq, wakeup_req}, 32'h3);
    apb(1'b1, OFS_FCLR, 32'h0000FFFE);
    rdchk("clr_one", OFS_FLAGS, 32'h6);
    apb(1'b1, OFS_FCLR, 32'h0);
    cyc(1);
    chk("irq_off", {30'h0, port_irq, wakeup_req}, 32'h0);
    // Filter on pin 3 only, pin 7 unfiltered, over every select code
    apb(1'b1, OFS_RISE, 32'h00000088);
    apb(1'b1, OFS_FALL, 32'h0);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, OFS_FILT, (32'(c) << 16) | 32'h8);
      apb(1'b1, OFS_FCLR, 32'h0);
      ext_lvl <= 16'h0088;
      cyc(1);
      ext_lvl <= 16'h0;
      cyc(3 * fper(c) + 6);
      rdchk("glitch", OFS_FLAGS, 32'h80);
      apb(1'b1, OFS_FCLR, 32'h0);
      ext_lvl <= 16'h0008;
      cyc(fper(c) + 1);
      rdchk("early", OFS_FLAGS, 32'h0);
      cyc(2 * fper(c) + 4);
      rdchk("held", OFS_FLAGS, 32'h8);
      ext_lvl <= 16'h0;
      cyc(3 * fper(c) + 6);
    end
    tally_and_finish();
  end

  initial begin
    cyc(20000);
    errors++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
